/* File: hdl/three_wire_config_serial_port.sv */
// three-wire serial configuration port: link framing, register store, system crossing
`timescale 1ns/100ps
// Functional notes
// RL1: frame starts at chip select falling followed by a shift clock rising edge.
// RL2: frame is a 16-bit instruction followed by data bytes set by length field.
// RL3: serial pins are processed only while chip select is low.
// RL4: chip select high between bytes stalls; position is kept and resumed.
// RL5: length field 11 streams bytes until chip select goes high.
// RL6: chip select high mid-byte discards the byte and restarts at an instruction.
// RL7: chip select high at power-up selects strap mode; serial traffic ignored. The port only raises o_strap_mode and still decodes later frames.
// RL8: chip select tied low gives two-wire operation, synchronised from reset.
// RL9: in two-wire use the master should keep to one to three byte transfers.
// RL10: without chip select activity streaming never ends.
// RL11: instruction decides write or readback and the transfer length.
// RL12: on readback the data pin turns to output after the instruction.
// RL13: bits travel msb first after reset; config register may select lsb first.
// RL14: input bits are sampled on shift clock rising edges; clock and select are inputs.
// RL15: bit order and soft reset bits are mirrored across the config nibbles.
// RL16: soft reset bit resets the port and always reads back as zero.
// RL17: instruction is read flag, two length bits, 13-bit address; 00/01/10 give 1/2/3.
// RL18: readback bits are launched on shift clock falling edges.
// RL19: address steps after each byte, down for msb first, up for lsb first.
module three_wire_config_serial_port
    import cfg_port_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_sclk,
    input  wire logic              i_cs_n,
    input  wire logic              i_sdio_in,
    output logic                   o_sdio_out,
    output logic                   o_sdio_oe_n,
    output cfg_port_pkg::cfg_write_t o_wr,
    output logic                   o_wr_valid,
    output logic                   o_lsb_first,
    output logic                   o_streaming,
    output logic                   o_soft_reset,
    output logic                   o_strap_mode,
    output logic                   o_frame_active
);
    import cfg_port_pkg::*;

    generate
        if (MEM_AW < 1 || MEM_AW > ADDR_BITS)
        begin : g_bad_aw
            $error("MEM_AW must lie between 1 and the address width");
        end
    endgenerate

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] shift16(input logic [15:0] sh, input logic b,
                                            input logic lsb);
        shift16 = lsb ? {b, sh[15:1]} : {sh[14:0], b};
    endfunction : shift16

    function automatic logic [7:0] shift8(input logic [7:0] sh, input logic b,
                                          input logic lsb);
        shift8 = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift8

    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
        step_addr = lsb ? a + 13'h0001 : a - 13'h0001;
    endfunction : step_addr

    function automatic logic in_mem(input logic [12:0] a);
        in_mem = (a >> MEM_AW) == 13'h0000;
    endfunction : in_mem

    // ------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------
    logic        gap_set;
    logic        gap_reg;
    phase_t      phase_reg;
    logic [3:0]  pos_reg;
    logic [15:0] instr_sh_reg;
    logic [7:0]  byte_sh_reg;
    logic        rd_reg;
    logic        stream_reg;
    logic [1:0]  left_reg;
    logic [12:0] addr_reg;
    logic        lsb_reg;
    logic        srst_tgl_reg;
    logic        wr_tgl_reg;
    cfg_write_t  wr_hold_reg;
    logic        rd_cfg_reg;

    logic        fresh;
    phase_t      phase_eff;
    logic [3:0]  pos_eff;
    logic [15:0] instr_next;
    logic [7:0]  byte_next;
    logic        instr_done;
    logic        byte_done;
    instr_t      decoded;
    logic [12:0] addr_next;
    logic [12:0] rd_issue_addr;
    logic        rd_issue;
    logic        wr_now;
    logic        cfg_hit;
    logic [7:0]  cfg_view;
    logic [7:0]  mem_rd;
    logic [7:0]  rd_byte;
    logic [2:0]  bit_idx;

    // chip select high holds this flag set; the first edge after it decides resume or restart
    assign gap_set = ~i_rstn | i_cs_n;

    always_ff @(posedge i_sclk or posedge gap_set)
    begin
        if (gap_set)
        begin
            gap_reg <= 1'b1;                                    // [RL3]
        end
        else
        begin
            gap_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    always_comb
    begin
        // a stream or a partial byte cannot resume across a gap
        fresh      = gap_reg && ((pos_reg != POS_RESET) ||
                     (phase_reg == PH_DATA && stream_reg));   // [RL6] [RL5] [RL1]
        phase_eff  = fresh ? PH_INSTR : phase_reg;              // [RL4]
        pos_eff    = fresh ? POS_RESET : pos_reg;
        instr_next = shift16(fresh ? 16'h0000 : instr_sh_reg, i_sdio_in, lsb_reg); // [RL13]
        byte_next  = shift8(byte_sh_reg, i_sdio_in, lsb_reg);
        instr_done = (phase_eff == PH_INSTR) && (pos_eff == INSTR_LAST_POS); // [RL2]
        byte_done  = (phase_eff == PH_DATA) && (pos_eff == BYTE_LAST_POS);
        decoded    = instr_t'(instr_next);                      // [RL17] [RL11]
        addr_next  = step_addr(addr_reg, lsb_reg);              // [RL19]
        rd_issue_addr = instr_done ? decoded.addr : addr_next;
        rd_issue   = instr_done ? decoded.rd : (byte_done && rd_reg);
        wr_now     = byte_done && !rd_reg;
        cfg_hit    = addr_reg == PORT_CFG_ADDR;
    end

    // ------------------------------------------------------------
    // frame sequencing, sampled on rising shift clock
    // ------------------------------------------------------------
    always_ff @(posedge i_sclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_reg    <= PH_INSTR;                           // [RL8]
            pos_reg      <= POS_RESET;
            instr_sh_reg <= 16'h0000;
            byte_sh_reg  <= 8'h00;
        end
        else if (!i_cs_n)                                       // [RL3] [RL14]
        begin
            instr_sh_reg <= instr_next;
            byte_sh_reg  <= byte_next;
            if (instr_done || byte_done)
            begin
                pos_reg <= POS_RESET;
            end
            else
            begin
                pos_reg <= pos_eff + 4'h1;
            end
            if (instr_done)
            begin
                phase_reg <= PH_DATA;
            end
            else if (byte_done && !stream_reg && left_reg == LEFT_RESET)
            begin
                phase_reg <= PH_INSTR;
            end
            else
            begin
                phase_reg <= phase_eff;
            end
        end
    end

    // transfer descriptor: direction, byte count, address
    always_ff @(posedge i_sclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rd_reg     <= 1'b0;
            stream_reg <= 1'b0;
            left_reg   <= LEFT_RESET;
            addr_reg   <= 13'h0000;
        end
        else if (!i_cs_n)
        begin
            if (instr_done)
            begin
                rd_reg     <= decoded.rd;                       // [RL11]
                stream_reg <= decoded.len == WL_STREAM;         // [RL5] [RL10]
                left_reg   <= decoded.len;                      // [RL17]
                addr_reg   <= decoded.addr;
            end
            else if (fresh)
            begin
                stream_reg <= 1'b0;
            end
            else if (byte_done)
            begin
                addr_reg <= addr_next;                          // [RL19]
                if (!stream_reg && left_reg != LEFT_RESET)
                begin
                    left_reg <= left_reg - 2'h1;                // [RL2]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // port configuration and write hand-off
    // ------------------------------------------------------------
    always_ff @(posedge i_sclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lsb_reg      <= 1'b0;                               // [RL13]
            srst_tgl_reg <= 1'b0;
        end
        else if (!i_cs_n && wr_now && cfg_hit)
        begin
            // either mirrored copy counts, so the byte decodes in any shift order
            if (byte_next[CFG_SRST_HI] | byte_next[CFG_SRST_LO])   // [RL15]
            begin
                lsb_reg      <= 1'b0;                           // [RL16]
                srst_tgl_reg <= ~srst_tgl_reg;
            end
            else
            begin
                lsb_reg <= byte_next[CFG_LSB_HI] | byte_next[CFG_LSB_LO]; // [RL15] [RL13]
            end
        end
    end

    // held stable for at least a byte time, long enough for the system side to catch it
    always_ff @(posedge i_sclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_tgl_reg  <= 1'b0;
            wr_hold_reg <= '0;
        end
        else if (!i_cs_n && wr_now)
        begin
            wr_tgl_reg       <= ~wr_tgl_reg;
            wr_hold_reg.addr <= addr_reg;
            wr_hold_reg.data <= byte_next;
        end
    end

    always_ff @(posedge i_sclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rd_cfg_reg <= 1'b0;
        end
        else if (!i_cs_n && rd_issue)
        begin
            rd_cfg_reg <= rd_issue_addr == PORT_CFG_ADDR;
        end
    end

    cfg_byte_mem #(
        .AW (MEM_AW)
    ) u_mem (
        .i_clk     (i_sclk),
        .i_rstn    (i_rstn),
        .i_wr_en   (!i_cs_n && wr_now && in_mem(addr_reg)),
        .i_wr_addr (addr_reg[MEM_AW-1:0]),
        .i_wr_data (byte_next),
        .i_rd_en   (!i_cs_n && rd_issue && in_mem(rd_issue_addr)),
        .i_rd_addr (rd_issue_addr[MEM_AW-1:0]),
        .o_rd_data (mem_rd)
    );

    // ------------------------------------------------------------
    // readback driver, launched on falling shift clock
    // ------------------------------------------------------------
    always_comb
    begin
        cfg_view = PORT_CFG_RESET;
        cfg_view[CFG_LSB_HI] = lsb_reg;
        cfg_view[CFG_LSB_LO] = lsb_reg;
        rd_byte  = rd_cfg_reg ? cfg_view : mem_rd;              // [RL16]
        bit_idx  = lsb_reg ? pos_reg[2:0] : 3'h7 - pos_reg[2:0];
    end

    always_ff @(negedge i_sclk or posedge gap_set)
    begin
        if (gap_set)
        begin
            o_sdio_oe_n <= 1'b1;                                // [RL3]
            o_sdio_out  <= 1'b0;
        end
        else
        begin
            o_sdio_oe_n <= !(phase_reg == PH_DATA && rd_reg);   // [RL12]
            o_sdio_out  <= rd_byte[bit_idx];                    // [RL18]
        end
    end

    // ------------------------------------------------------------
    // system clock side
    // ------------------------------------------------------------
    logic       cs_meta;
    logic       cs_sync;
    logic [2:0] wr_sync;
    logic [2:0] srst_sync;
    logic [1:0] lsb_sync;
    logic [1:0] strm_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cs_meta   <= 1'b1;
            cs_sync   <= 1'b1;
            wr_sync   <= 3'h0;
            srst_sync <= 3'h0;
            lsb_sync  <= 2'h0;
            strm_sync <= 2'h0;
        end
        else
        begin
            cs_meta   <= i_cs_n;
            cs_sync   <= cs_meta;
            wr_sync   <= {wr_sync[1:0], wr_tgl_reg};
            srst_sync <= {srst_sync[1:0], srst_tgl_reg};
            lsb_sync  <= {lsb_sync[0], lsb_reg};
            strm_sync <= {strm_sync[0], stream_reg};
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_wr       <= '0;
            o_wr_valid <= 1'b0;
        end
        else
        begin
            o_wr_valid <= wr_sync[2] ^ wr_sync[1];
            if (wr_sync[2] ^ wr_sync[1])
            begin
                o_wr <= wr_hold_reg;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_soft_reset   <= 1'b0;
            o_lsb_first    <= 1'b0;
            o_streaming    <= 1'b0;
            o_frame_active <= 1'b0;
        end
        else
        begin
            o_soft_reset   <= srst_sync[2] ^ srst_sync[1];      // [RL16]
            o_lsb_first    <= lsb_sync[1];
            o_streaming    <= strm_sync[1] & ~cs_sync;
            o_frame_active <= ~cs_sync;
        end
    end

    // strap level caught once the synchroniser has settled after release
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            strap_cnt    <= 2'h0;
            strap_done   <= 1'b0;
            o_strap_mode <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == STRAP_WAIT)
            begin
                strap_done   <= 1'b1;
                o_strap_mode <= cs_sync;                        // [RL7]
            end
        end
    end

endmodule : three_wire_config_serial_port

/* File: include/cfg_port_pkg.sv */
// constants and carrier types for the three-wire configuration port
package cfg_port_pkg;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int         INSTR_BITS     = 16;
    localparam int         BYTE_BITS      = 8;
    localparam int         ADDR_BITS      = 13;
    localparam logic [3:0] INSTR_LAST_POS = 4'hf;
    localparam logic [3:0] BYTE_LAST_POS  = 4'h7;
    localparam logic [3:0] POS_RESET      = 4'h0;
    localparam logic [1:0] WL_STREAM      = 2'h3;
    localparam logic [1:0] LEFT_RESET     = 2'h0;

    // ------------------------------------------------------------
    // port configuration byte
    // ------------------------------------------------------------
    localparam logic [12:0] PORT_CFG_ADDR  = 13'h0000;
    localparam logic [7:0]  PORT_CFG_RESET = 8'h18;
    localparam int          CFG_LSB_HI     = 6;
    localparam int          CFG_LSB_LO     = 1;
    localparam int          CFG_SRST_HI    = 5;
    localparam int          CFG_SRST_LO    = 2;

    // ------------------------------------------------------------
    // system side
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [0:0] {
        PH_INSTR = 1'b0,
        PH_DATA  = 1'b1
    } phase_t;

    typedef struct packed {
        logic        rd;
        logic [1:0]  len;
        logic [12:0] addr;
    } instr_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0]  data;
    } cfg_write_t;

endpackage : cfg_port_pkg

/* File: hdl/cfg_byte_mem.sv */
// byte-wide register memory with registered read port
`timescale 1ns/100ps
module cfg_byte_mem #(
    parameter int AW = 8
) (
    input  wire logic          i_clk,
    input  wire logic          i_rstn,
    input  wire logic          i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [7:0]    i_wr_data,
    input  wire logic          i_rd_en,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [7:0]    o_rd_data
);

    // contents are not cleared by reset: an array of this size wants no reset tree
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk)
    begin
        if (i_wr_en)
        begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rd_data <= 8'h00;
        end
        else if (i_rd_en)
        begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule : cfg_byte_mem

/* File: verification/cfg_port_asserts.sv */
// concurrent checks on the three-wire configuration port top level
`timescale 1ns/100ps
module cfg_port_checker
    import cfg_port_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic                     i_clk,
    input wire logic                     i_rstn,
    input wire logic                     i_sclk,
    input wire logic                     i_cs_n,
    input wire logic                     i_sdio_in,
    input wire logic                     o_sdio_out,
    input wire logic                     o_sdio_oe_n,
    input wire cfg_port_pkg::cfg_write_t o_wr,
    input wire logic                     o_wr_valid,
    input wire logic                     o_lsb_first,
    input wire logic                     o_streaming,
    input wire logic                     o_soft_reset,
    input wire logic                     o_strap_mode,
    input wire logic                     o_frame_active
);
    // ------------------------------------------------------------
    // link framing and system pulses
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_cs_up;
        $rose(i_cs_n);
    endsequence
    sequence s_cs_down;
        $fell(i_cs_n);
    endsequence
    property p_oe_cs;
        i_cs_n |-> o_sdio_oe_n;
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("pin driven while deselected");
    property p_frame_on;
        s_cs_down |-> ##[1:4] o_frame_active;
    endproperty
    a_frame_on: assert property (p_frame_on) else $error("frame not seen");
    property p_frame_off;
        s_cs_up |-> ##[1:4] !o_frame_active;
    endproperty
    a_frame_off: assert property (p_frame_off) else $error("frame not closed");
    property p_stream_end;
        s_cs_up |-> ##[1:5] !o_streaming;
    endproperty
    a_stream_end: assert property (p_stream_end) else $error("stream kept");
    property p_wr_pulse;
        o_wr_valid |=> !o_wr_valid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_wr_frame;
        o_wr_valid |-> o_frame_active || $past(o_frame_active, 3);
    endproperty
    a_wr_frame: assert property (p_wr_frame) else $error("write outside frame");
    property p_soft;
        o_soft_reset |=> !o_soft_reset ##[0:3] !o_lsb_first;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_out_fall;
        $changed(o_sdio_out) |-> !i_sclk;
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("bit not on falling edge");
    property p_oe_fall;
        $fell(o_sdio_oe_n) |-> !i_cs_n && !i_sclk;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("bad turnaround");
endmodule : cfg_port_checker

bind three_wire_config_serial_port cfg_port_checker #(.MEM_AW(MEM_AW)) chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_sdio_in(i_sdio_in), .o_sdio_out(o_sdio_out), .o_sdio_oe_n(o_sdio_oe_n),
    .o_wr(o_wr), .o_wr_valid(o_wr_valid), .o_lsb_first(o_lsb_first),
    .o_streaming(o_streaming), .o_soft_reset(o_soft_reset),
    .o_strap_mode(o_strap_mode), .o_frame_active(o_frame_active));

/* File: verification/cfg_host_model.sv */
// serial master model driving the configuration port link
`timescale 1ns/100ps
module cfg_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdio,
    input  wire logic i_sdio_out,
    input  wire logic i_sdio_oe_n
);
    // ------------------------------------------------------------
    // pin and bit shifting
    // ------------------------------------------------------------
    logic host_en;
    logic host_bit;
    logic lsb_mode;
    // released pin sinks to the internal pull-down
    assign o_sdio = !i_sdio_oe_n ? i_sdio_out : (host_en ? host_bit : 1'b0);
    initial
    begin
        o_sclk   = 1'b0;
        o_cs_n   = 1'b1;
        host_en  = 1'b0;
        host_bit = 1'b0;
        lsb_mode = 1'b0;
    end
    // clock only moves inside tasks, so it stands still between frames
    task cs_set(input logic v);
        o_cs_n  = v;
        host_en = 1'b0;
        #64;
    endtask : cs_set
    task put_bit(input logic b);
        host_en  = 1'b1;
        host_bit = b;
        #16 o_sclk = 1'b1;
        #16 o_sclk = 1'b0;
    endtask : put_bit
    task send_word(input logic [15:0] w);
        for (int i = 0; i < 16; i++)
            put_bit(w[lsb_mode ? i : 15 - i]);
    endtask : send_word
    task send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            put_bit(b[lsb_mode ? i : 7 - i]);
    endtask : send_byte
    task get_byte(output logic [7:0] b);
        host_en = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            #16 o_sclk = 1'b1;
            b[lsb_mode ? i : 7 - i] = o_sdio;
            #16 o_sclk = 1'b0;
        end
    endtask : get_byte
endmodule : cfg_host_model

/* File: verification/test_three_wire_config_serial_port.sv */
// self-checking bench for the three-wire configuration port
`timescale 1ns/100ps
module test_three_wire_config_serial_port;
    import cfg_port_pkg::*;
    logic       clk;
    logic       rst_n;
    wire logic  sclk;
    wire logic  cs_n;
    wire logic  sdio;
    wire logic  sdio_out;
    wire logic  sdio_oe_n;
    wire cfg_write_t wr;
    wire logic  wr_valid;
    wire logic  lsb_first;
    wire logic  streaming;
    wire logic  soft_reset;
    wire logic  strap_mode;
    wire logic  frame_active;
    logic [7:0] rb;
    int         err_total;
    int         total_checks;
    int         soft_seen;
    cfg_write_t wq[$];

    three_wire_config_serial_port #(.MEM_AW(8)) dut (
        .i_clk(clk), .i_rstn(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio_in(sdio),
        .o_sdio_out(sdio_out), .o_sdio_oe_n(sdio_oe_n), .o_wr(wr), .o_wr_valid(wr_valid),
        .o_lsb_first(lsb_first), .o_streaming(streaming), .o_soft_reset(soft_reset),
        .o_strap_mode(strap_mode), .o_frame_active(frame_active));
    cfg_host_model host (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio), .i_sdio_out(sdio_out),
        .i_sdio_oe_n(sdio_oe_n));

    // ------------------------------------------------------------
    // monitors and helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // falling edge sampling keeps clear of the register updates
    always @(negedge clk)
    begin
        if (wr_valid === 1'b1)
            wq.push_back(wr);
        if (soft_reset === 1'b1)
            soft_seen++;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task settle;
        repeat (8) @(negedge clk);
    endtask : settle
    task exp_wr(input logic [12:0] a, input logic [7:0] v);
        check(wq.size() > 0, 1'b1);
        if (wq.size() > 0)
            check(wq.pop_front(), {a, v});
    endtask : exp_wr
    task reset_dut;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask : reset_dut
    task xfer(input logic rd, input logic [1:0] len, input logic [12:0] addr,
              input logic [7:0] d[$], input logic stall, input logic two);
        if (!two)
            host.cs_set(1'b0);
        host.send_word({rd, len, addr});
        foreach (d[i])
        begin
            if (stall && i > 0)
            begin
                host.cs_set(1'b1);
                host.cs_set(1'b0);
            end
            if (rd)
            begin
                host.get_byte(rb);
                check(rb, d[i]);
            end
            else
                host.send_byte(d[i]);
        end
        if (!two)
            host.cs_set(1'b1);
        settle();
    endtask : xfer
    task complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        clk          = 1'b0;
        rst_n        = 1'b0;
        err_total    = 0;
        total_checks = 0;
        soft_seen    = 0;
        #1;
        host.o_cs_n = 1'b0;
        reset_dut();
        check(strap_mode, 1'b0);
        check(sdio_oe_n, 1'b1);
        check(lsb_first, 1'b0);
        xfer(1'b0, 2'h0, 13'h005, '{8'ha5}, 1'b0, 1'b1);
        exp_wr(13'h005, 8'ha5);
        xfer(1'b1, 2'h0, 13'h005, '{8'ha5}, 1'b0, 1'b1);
        $display("test two_wire done");
        host.cs_set(1'b1);
        xfer(1'b0, 2'h2, 13'h012, '{8'h11, 8'h22, 8'h33}, 1'b1, 1'b0);
        for (int i = 0; i < 3; i++)
            exp_wr(13'(13'h012 - i), 8'(8'h11 * (i + 1)));
        xfer(1'b1, 2'h2, 13'h012, '{8'h11, 8'h22, 8'h33}, 1'b0, 1'b0);
        xfer(1'b0, 2'h1, 13'h040, '{8'h5a, 8'h3c}, 1'b0, 1'b0);
        exp_wr(13'h040, 8'h5a);
        exp_wr(13'h03f, 8'h3c);
        xfer(1'b0, 2'h0, 13'h100, '{8'h99}, 1'b0, 1'b0);
        exp_wr(13'h100, 8'h99);
        $display("test multi_byte done");
        host.cs_set(1'b0);
        host.send_word({1'b0, WL_STREAM, 13'h020});
        for (int i = 1; i < 5; i++)
            host.send_byte(8'(i));
        check(streaming, 1'b1);
        check(frame_active, 1'b1);
        host.cs_set(1'b1);
        settle();
        check(streaming, 1'b0);
        check(frame_active, 1'b0);
        for (int i = 0; i < 4; i++)
            exp_wr(13'(13'h020 - i), 8'(i + 1));
        xfer(1'b1, WL_STREAM, 13'h020, '{8'h01, 8'h02, 8'h03, 8'h04}, 1'b0, 1'b0);
        $display("test stream done");
        host.cs_set(1'b0);
        host.send_word({1'b0, 2'h0, 13'h030});
        repeat (4) host.put_bit(1'b1);
        host.cs_set(1'b1);
        host.cs_set(1'b0);
        repeat (5) host.put_bit(1'b1);
        host.cs_set(1'b1);
        settle();
        check(wq.size(), 0);
        xfer(1'b0, 2'h0, 13'h030, '{8'hc3}, 1'b0, 1'b0);
        exp_wr(13'h030, 8'hc3);
        xfer(1'b1, 2'h0, 13'h030, '{8'hc3}, 1'b0, 1'b0);
        $display("test abort done");
        xfer(1'b1, 2'h0, PORT_CFG_ADDR, '{PORT_CFG_RESET}, 1'b0, 1'b0);
        xfer(1'b0, 2'h0, PORT_CFG_ADDR, '{8'h42}, 1'b0, 1'b0);
        wq.delete();
        check(lsb_first, 1'b1);
        host.lsb_mode = 1'b1;
        xfer(1'b1, 2'h0, PORT_CFG_ADDR, '{8'h5a}, 1'b0, 1'b0);
        xfer(1'b0, 2'h1, 13'h050, '{8'h77, 8'h88}, 1'b0, 1'b0);
        exp_wr(13'h050, 8'h77);
        exp_wr(13'h051, 8'h88);
        xfer(1'b0, 2'h0, PORT_CFG_ADDR, '{8'h24}, 1'b0, 1'b0);
        check(soft_seen, 1);
        check(lsb_first, 1'b0);
        host.lsb_mode = 1'b0;
        wq.delete();
        xfer(1'b1, 2'h0, PORT_CFG_ADDR, '{PORT_CFG_RESET}, 1'b0, 1'b0);
        $display("test config done");
        reset_dut();
        check(strap_mode, 1'b1);
        host.send_word({1'b0, 2'h0, 13'h005});
        host.send_byte(8'hff);
        settle();
        check(wq.size(), 0);
        $display("test strap done");
        complete_run();
    end

    // about five times the expected length of the sequence
    initial
    begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule : test_three_wire_config_serial_port
